/* File: hw/usb_ps2_status_control_regs.sv */
// Bus status, endpoint flag and bus select registers of a USB and PS/2 pointing device.
//
// Behaviour
// - Bit 0 reads suspend state.
// - Bit 1 drives remote wake-up, resets low.
// - Bus reset sets sticky bit 2 flag.
// - Resume event sets read-only bit 3.
// - Bits 6 and 7 drive lines, reset high.
// - Bits 4 and 5 show live line levels.
// - Endpoint access sets flag, gated interrupt request.
// - Endpoint flags hold; no new event while set.
// - Bit 4 selects the PS/2 link.
// - Bit 5 selects the USB link.
// - Bit 7 firmware mode flag, reset zero.
// - Select bits give pins to firmware or engine.
// - Idle over 3 ms in USB mode enters suspend, interrupts.
`timescale 1ns/1ps
module usb_ps2_status_control_regs #(
    parameter int IDLE_CYCLES = usb_ps2_regs_pkg::IDLE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic usb_bus_active,
    input wire logic usb_bus_reset,
    input wire logic usb_resume,
    input wire logic [1:0] ep_access,
    input wire logic usb_int_enable,
    input wire logic stack_full,
    input wire logic engine_dm_out,
    input wire logic engine_dp_out,
    input wire logic engine_oe,
    input wire logic dminus_in,
    input wire logic dplus_in,
    output logic dminus_out,
    output logic dminus_oe,
    output logic dplus_out,
    output logic dplus_oe,
    output logic remote_wakeup_drive,
    output logic usb_irq,
    output logic irq
);
    // Counter wide enough for the idle limit.
    localparam int CW = $clog2(IDLE_CYCLES + 1);
    localparam logic [CW-1:0] IDLE_LIMIT = CW'(IDLE_CYCLES);

    // Stored control and status bits.
    logic suspend;
    logic bus_reset_event;
    logic resume_seen;
    logic kbd_data_line_out;
    logic kbd_clock_line_out;
    logic control_endpoint_request;
    logic interrupt_endpoint_request;
    logic legacy_link_select;
    logic serial_bus_select;
    logic usb_flag;
    logic [usb_ps2_regs_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [usb_ps2_regs_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [CW-1:0] idle_count;
    // Two-stage synchronisers for the pad inputs.
    logic dm_s1;
    logic dm_s2;
    logic dp_s1;
    logic dp_s2;

    // Decoded accesses.
    logic wr_bus;
    logic wr_ep;
    logic wr_mask;
    logic rd_stat;
    logic legacy_mode;
    logic serial_mode;
    logic suspend_enter;
    logic suspend_leave;
    logic ep0_new;
    logic ep1_new;
    logic [usb_ps2_regs_pkg::IRQ_WIDTH-1:0] events;

    // Address match, shared by the four strobe decodes below.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_bus = wr && hit(addr, usb_ps2_regs_pkg::BUS_STATUS_CONTROL_OFS);
    assign wr_ep = wr && hit(addr, usb_ps2_regs_pkg::ENDPOINT_FLAGS_BUS_SELECT_OFS);
    assign wr_mask = wr && hit(addr, usb_ps2_regs_pkg::IRQ_MASK_OFS);
    assign rd_stat = rd && hit(addr, usb_ps2_regs_pkg::IRQ_STATUS_OFS);
    assign legacy_mode = legacy_link_select && !serial_bus_select;
    assign serial_mode = serial_bus_select && !legacy_link_select;
    assign suspend_enter = serial_mode && !suspend && !usb_bus_active
        && (idle_count == IDLE_LIMIT);
    assign suspend_leave = suspend && usb_bus_active;
    assign ep0_new = ep_access[0] && !control_endpoint_request;
    assign ep1_new = ep_access[1] && !interrupt_endpoint_request;

    // Collected events feed both the sticky status and the engine interrupt.
    always_comb begin
        events = '0;
        events[usb_ps2_regs_pkg::IRQ_SUSPEND_BIT] = suspend_enter || suspend_leave;
        events[usb_ps2_regs_pkg::IRQ_BUS_RESET_BIT] = usb_bus_reset;
        events[usb_ps2_regs_pkg::IRQ_RESUME_BIT] = usb_resume;
        events[usb_ps2_regs_pkg::IRQ_EP0_BIT] = ep0_new;
        events[usb_ps2_regs_pkg::IRQ_EP1_BIT] = ep1_new;
    end

    // Pad synchronisers; only the second stage is read by logic.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dm_s1 <= 1'b1;
            dm_s2 <= 1'b1;
            dp_s1 <= 1'b1;
            dp_s2 <= 1'b1;
        end else begin
            dm_s1 <= dminus_in;
            dm_s2 <= dm_s1;
            dp_s1 <= dplus_in;
            dp_s2 <= dp_s1;
        end
    end

    // Idle counter restarts on any bus activity or outside USB mode.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            idle_count <= '0;
        end else if (usb_bus_active || !serial_mode || suspend) begin
            idle_count <= '0;
        end else if (idle_count != IDLE_LIMIT) begin
            idle_count <= idle_count + CW'(1);
        end
    end

    // Suspend and resume state; resume is remembered until the bus wakes.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            suspend <= 1'b0;
            resume_seen <= 1'b0;
        end else begin
            if (suspend_enter) begin
                suspend <= 1'b1;
            end else if (suspend_leave) begin
                suspend <= 1'b0;
            end
            if (usb_resume) begin
                resume_seen <= 1'b1;
            end else if (suspend_leave) begin
                resume_seen <= 1'b0;
            end
        end
    end

    // Bus status and control register writes; read-only bits are not stored.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            remote_wakeup_drive <= 1'b0;
            bus_reset_event <= 1'b0;
            kbd_data_line_out <= usb_ps2_regs_pkg::DATA_OUT_RESET;
            kbd_clock_line_out <= usb_ps2_regs_pkg::CLOCK_OUT_RESET;
        end else begin
            if (wr_bus) begin
                remote_wakeup_drive <= wdata[usb_ps2_regs_pkg::WAKEUP_BIT];
                kbd_data_line_out <= wdata[usb_ps2_regs_pkg::DATA_OUT_BIT];
                kbd_clock_line_out <= wdata[usb_ps2_regs_pkg::CLOCK_OUT_BIT];
            end
            if (usb_bus_reset) begin
                bus_reset_event <= 1'b1;
            end else if (wr_bus) begin
                bus_reset_event <= wdata[usb_ps2_regs_pkg::BUS_RESET_BIT];
            end
        end
    end

    // Endpoint flags: hardware set wins over a firmware clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            control_endpoint_request <= 1'b0;
            interrupt_endpoint_request <= 1'b0;
        end else begin
            if (ep0_new) begin
                control_endpoint_request <= 1'b1;
            end else if (wr_ep) begin
                control_endpoint_request <= wdata[usb_ps2_regs_pkg::EP0_BIT];
            end
            if (ep1_new) begin
                interrupt_endpoint_request <= 1'b1;
            end else if (wr_ep) begin
                interrupt_endpoint_request <= wdata[usb_ps2_regs_pkg::EP1_BIT];
            end
        end
    end

    // Bus select and firmware mode flag; reserved bits are dropped.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            legacy_link_select <= 1'b0;
            serial_bus_select <= 1'b0;
            usb_flag <= 1'b0;
        end else if (wr_ep) begin
            legacy_link_select <= wdata[usb_ps2_regs_pkg::LEGACY_SEL_BIT];
            serial_bus_select <= wdata[usb_ps2_regs_pkg::SERIAL_SEL_BIT];
            usb_flag <= wdata[usb_ps2_regs_pkg::USB_FLAG_BIT];
        end
    end

    // Engine interrupt request, gated by enable and stack room.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            usb_irq <= 1'b0;
        end else begin
            usb_irq <= (|events) && usb_int_enable && !stack_full;
        end
    end

    // Sticky status cleared by reading it; a new event wins over the clear.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_status <= '0;
        end else if (rd_stat) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Mask register of the same layout as the status.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= wdata[usb_ps2_regs_pkg::IRQ_WIDTH-1:0];
        end
    end

    // Level interrupt, high while an unmasked status bit is set.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Pad drive: open-drain lines in PS/2 mode, the engine in USB mode.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dminus_out <= 1'b0;
            dminus_oe <= 1'b0;
            dplus_out <= 1'b0;
            dplus_oe <= 1'b0;
        end else if (legacy_mode) begin
            dminus_out <= 1'b0;
            dminus_oe <= !kbd_data_line_out;
            dplus_out <= 1'b0;
            dplus_oe <= !kbd_clock_line_out;
        end else if (serial_mode) begin
            dminus_out <= engine_dm_out;
            dminus_oe <= engine_oe;
            dplus_out <= engine_dp_out;
            dplus_oe <= engine_oe;
        end else begin
            // Neither or both links chosen: leave both pads floating.
            dminus_out <= 1'b0;
            dminus_oe <= 1'b0;
            dplus_out <= 1'b0;
            dplus_oe <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; write-only bits read as zero.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= '0;
            if (rd) begin
                unique case (addr)
                    usb_ps2_regs_pkg::BUS_STATUS_CONTROL_OFS: begin
                        rdata[usb_ps2_regs_pkg::SUSPEND_BIT] <= suspend;
                        rdata[usb_ps2_regs_pkg::BUS_RESET_BIT] <= bus_reset_event;
                        rdata[usb_ps2_regs_pkg::RESUME_BIT] <= resume_seen;
                        rdata[usb_ps2_regs_pkg::DATA_IN_BIT] <= dm_s2;
                        rdata[usb_ps2_regs_pkg::CLOCK_IN_BIT] <= dp_s2;
                    end
                    usb_ps2_regs_pkg::ENDPOINT_FLAGS_BUS_SELECT_OFS: begin
                        rdata[usb_ps2_regs_pkg::EP0_BIT] <= control_endpoint_request;
                        rdata[usb_ps2_regs_pkg::EP1_BIT] <= interrupt_endpoint_request;
                        rdata[usb_ps2_regs_pkg::LEGACY_SEL_BIT] <= legacy_link_select;
                        rdata[usb_ps2_regs_pkg::SERIAL_SEL_BIT] <= serial_bus_select;
                        rdata[usb_ps2_regs_pkg::USB_FLAG_BIT] <= usb_flag;
                    end
                    usb_ps2_regs_pkg::IRQ_STATUS_OFS: begin
                        rdata[usb_ps2_regs_pkg::IRQ_WIDTH-1:0] <= irq_status;
                    end
                    usb_ps2_regs_pkg::IRQ_MASK_OFS: begin
                        rdata[usb_ps2_regs_pkg::IRQ_WIDTH-1:0] <= irq_mask;
                    end
                    // Unmapped addresses answer with zero.
                    default: begin
                        rdata <= '0;
                    end
                endcase
            end
        end
    end

    // Checks on the register behaviour.
    AST_SUSPEND_READ: assert property (@(posedge clk) disable iff (!nrst)
        rd && hit(addr, usb_ps2_regs_pkg::BUS_STATUS_CONTROL_OFS)
        |=> rdata[usb_ps2_regs_pkg::SUSPEND_BIT] == $past(suspend))
        else $error("Suspend bit does not read the suspend state.");

    AST_WAKEUP_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        wr_bus |=> remote_wakeup_drive == $past(wdata[usb_ps2_regs_pkg::WAKEUP_BIT]))
        else $error("Wake-up drive did not follow the write.");

    AST_BUS_RESET_SET: assert property (@(posedge clk) disable iff (!nrst)
        usb_bus_reset |=> bus_reset_event ##1 $past(rd_stat)
        || irq_status[usb_ps2_regs_pkg::IRQ_BUS_RESET_BIT])
        else $error("Bus reset did not set its flag and status.");

    AST_RESUME_SET: assert property (@(posedge clk) disable iff (!nrst)
        usb_resume |=> resume_seen)
        else $error("Resume event did not set the resume bit.");

    AST_LEGACY_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
        legacy_mode && !kbd_data_line_out |=> dminus_oe && !dminus_out)
        else $error("Data line not pulled low in PS/2 mode.");

    AST_LINE_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
        rd && hit(addr, usb_ps2_regs_pkg::BUS_STATUS_CONTROL_OFS)
        |=> rdata[usb_ps2_regs_pkg::CLOCK_IN_BIT] == $past(dp_s2))
        else $error("Clock line level misread.");

    AST_EP_IRQ_GATE: assert property (@(posedge clk) disable iff (!nrst)
        ep0_new && usb_int_enable && !stack_full
        |=> control_endpoint_request && usb_irq)
        else $error("Endpoint access did not flag and interrupt.");

    AST_EP_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        control_endpoint_request && !wr_ep |=> control_endpoint_request)
        else $error("Endpoint flag dropped without a firmware write.");

    AST_NO_IRQ_FULL: assert property (@(posedge clk) disable iff (!nrst)
        stack_full |=> !usb_irq)
        else $error("Interrupt raised with a full stack.");

    AST_SELECT_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
        serial_mode |=> dplus_oe == $past(engine_oe) && dplus_out == $past(engine_dp_out))
        else $error("Engine does not own the pads in USB mode.");

    AST_SUSPEND_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
        suspend_enter |=> suspend ##1 $past(rd_stat)
        || irq_status[usb_ps2_regs_pkg::IRQ_SUSPEND_BIT])
        else $error("Idle limit did not enter suspend with status.");

    AST_SELECT_STORE: assert property (@(posedge clk) disable iff (!nrst)
        wr_ep |=> legacy_link_select == $past(wdata[usb_ps2_regs_pkg::LEGACY_SEL_BIT])
        && usb_flag == $past(wdata[usb_ps2_regs_pkg::USB_FLAG_BIT]))
        else $error("Select or mode flag not stored.");

    AST_READ_ONLY: assert property (@(posedge clk) disable iff (!nrst)
        wr_bus && !suspend_enter && !suspend_leave |=> suspend == $past(suspend))
        else $error("Write changed the read-only suspend bit.");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
        irq == $past(|(irq_status & irq_mask)))
        else $error("Interrupt output does not match masked status.");
endmodule : usb_ps2_status_control_regs

/* File: hw/usb_ps2_regs_pkg.sv */
// Package with offsets, bit positions, reset values and timing for the bus status registers.
package usb_ps2_regs_pkg;
    // Register offsets on the firmware port.
    localparam logic [7:0] BUS_STATUS_CONTROL_OFS = 8'h1a;
    localparam logic [7:0] ENDPOINT_FLAGS_BUS_SELECT_OFS = 8'h1b;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h21;

    // Bus status and control register fields.
    localparam int SUSPEND_BIT = 0;
    localparam int WAKEUP_BIT = 1;
    localparam int BUS_RESET_BIT = 2;
    localparam int RESUME_BIT = 3;
    localparam int DATA_IN_BIT = 4;
    localparam int CLOCK_IN_BIT = 5;
    localparam int DATA_OUT_BIT = 6;
    localparam int CLOCK_OUT_BIT = 7;

    // Endpoint flags and bus select register fields.
    localparam int EP0_BIT = 0;
    localparam int EP1_BIT = 1;
    localparam int LEGACY_SEL_BIT = 4;
    localparam int SERIAL_SEL_BIT = 5;
    localparam int USB_FLAG_BIT = 7;

    // Interrupt status and mask fields.
    localparam int IRQ_SUSPEND_BIT = 0;
    localparam int IRQ_BUS_RESET_BIT = 1;
    localparam int IRQ_RESUME_BIT = 2;
    localparam int IRQ_EP0_BIT = 3;
    localparam int IRQ_EP1_BIT = 4;
    localparam int IRQ_WIDTH = 5;

    // Reset values of the line drive bits.
    localparam logic DATA_OUT_RESET = 1'b1;
    localparam logic CLOCK_OUT_RESET = 1'b1;

    // Idle time before suspend and the clock rate.
    localparam int IDLE_TIME_US = 3000;
    localparam int CLK_MHZ = 125;
    localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
endpackage : usb_ps2_regs_pkg

/* File: test/usb_host_model.sv */
// Behavioural USB engine and line host that face the register block's pins.
`timescale 1ns/1ps
module usb_host_model (
    input wire logic clk,
    input wire logic dminus_out,
    input wire logic dminus_oe,
    input wire logic dplus_out,
    input wire logic dplus_oe,
    output logic usb_bus_active,
    output logic usb_bus_reset,
    output logic usb_resume,
    output logic [1:0] ep_access,
    output logic engine_dm_out,
    output logic engine_dp_out,
    output logic engine_oe,
    output logic dminus_in,
    output logic dplus_in
);
    // Host pulls on each line; without them the pull-ups win.
    logic [1:0] pull = 2'h0;
    // All engine outputs start quiet, with the bus busy.
    initial begin
        usb_bus_active = 1'b1;
        {ep_access, usb_resume, usb_bus_reset} = 4'h0;
        {engine_dm_out, engine_dp_out, engine_oe} = 3'h0;
    end
    assign dminus_in = (dminus_oe ? dminus_out : 1'b1) & ~pull[0];
    assign dplus_in = (dplus_oe ? dplus_out : 1'b1) & ~pull[1];
    // One-cycle event pulse: bit 0 bus reset, bit 1 resume, bits 3:2 endpoints.
    task automatic pulse(input logic [3:0] sel);
        @(posedge clk);
        {ep_access, usb_resume, usb_bus_reset} <= sel;
        @(posedge clk);
        {ep_access, usb_resume, usb_bus_reset} <= 4'h0;
    endtask : pulse
    // Engine pad drive, changed just after an edge.
    task automatic engine(input logic [2:0] v);
        @(posedge clk);
        {engine_dm_out, engine_dp_out, engine_oe} <= v;
    endtask : engine
    // Host pull on the data (bit 0) and clock (bit 1) lines.
    task automatic set_pull(input logic [1:0] p);
        @(posedge clk);
        pull <= p;
    endtask : set_pull
    // Bus traffic level; low lets the idle timer run.
    task automatic busy(input logic a);
        @(posedge clk);
        usb_bus_active <= a;
    endtask : busy
endmodule : usb_host_model

/* File: test/test_usb_ps2_status_control_regs.sv */
// Self-checking bench for the bus status and endpoint flag registers.
`timescale 1ns/1ps
module test_usb_ps2_status_control_regs;
    localparam logic [7:0] BSC = usb_ps2_regs_pkg::BUS_STATUS_CONTROL_OFS;
    localparam logic [7:0] EPS = usb_ps2_regs_pkg::ENDPOINT_FLAGS_BUS_SELECT_OFS;
    localparam logic [7:0] IST = usb_ps2_regs_pkg::IRQ_STATUS_OFS;
    localparam logic [7:0] IMK = usb_ps2_regs_pkg::IRQ_MASK_OFS;
    // Short idle count keeps the suspend test brief.
    localparam int IDLE = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic usb_int_enable = 1'b1;
    logic stack_full = 1'b0;
    logic [7:0] rdata;
    logic usb_bus_active, usb_bus_reset, usb_resume, engine_dm_out, engine_dp_out;
    logic engine_oe, dminus_in, dplus_in, dminus_out, dminus_oe, dplus_out, dplus_oe;
    logic [1:0] ep_access;
    logic remote_wakeup_drive, usb_irq, irq;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pulses = 0;
    logic [7:0] v;
    logic [7:0] r;
    int n;
    always #4 clk = ~clk;
    usb_ps2_status_control_regs #(.IDLE_CYCLES(IDLE)) dut_u (.clk(clk), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .usb_bus_active(usb_bus_active), .usb_bus_reset(usb_bus_reset),
        .usb_resume(usb_resume), .ep_access(ep_access), .usb_int_enable(usb_int_enable),
        .stack_full(stack_full), .engine_dm_out(engine_dm_out),
        .engine_dp_out(engine_dp_out), .engine_oe(engine_oe), .dminus_in(dminus_in),
        .dplus_in(dplus_in), .dminus_out(dminus_out), .dminus_oe(dminus_oe),
        .dplus_out(dplus_out), .dplus_oe(dplus_oe),
        .remote_wakeup_drive(remote_wakeup_drive), .usb_irq(usb_irq), .irq(irq));
    usb_host_model host_u (.clk(clk), .dminus_out(dminus_out), .dminus_oe(dminus_oe),
        .dplus_out(dplus_out), .dplus_oe(dplus_oe), .usb_bus_active(usb_bus_active),
        .usb_bus_reset(usb_bus_reset), .usb_resume(usb_resume), .ep_access(ep_access),
        .engine_dm_out(engine_dm_out), .engine_dp_out(engine_dp_out),
        .engine_oe(engine_oe), .dminus_in(dminus_in), .dplus_in(dplus_in));
    // Counts interrupt pulses; a hang is cut short by the cycle ceiling.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (usb_irq === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            finish_test();
        end
    end
    // Line level seen by firmware: drive bit wired-AND with the host pull.
    function automatic logic line(input logic drive, input logic pull);
        return drive & ~pull;
    endfunction : line
    // Status byte in USB mode with floating pads.
    function automatic logic [7:0] bsc(input logic susp, input logic flag, input logic res);
        return {4'h3, res, flag, 1'b0, susp};
    endfunction : bsc
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // Main sequence: reset, wake-up, USB mode events, suspend, then PS/2 lines.
    initial begin
        void'($urandom(32'h3a922ed5));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(BSC, r);
        check("bsc reset", 8'h30, r);
        rd_reg(EPS, r);
        check("eps reset", 8'h00, r);
        check("pins reset", 8'h00, {remote_wakeup_drive, dminus_oe, dplus_oe, irq});
        // Read-only bits ignore writes; write-only bits read back zero.
        wr_reg(BSC, 8'hcb);
        rd_reg(BSC, r);
        check("bsc ro", 8'h30, r);
        check("wakeup", 8'h01, {7'h0, remote_wakeup_drive});
        wr_reg(IMK, 8'h1f);
        rd_reg(IMK, r);
        check("mask", 8'h1f, r);
        rd_reg(8'h77, r);
        check("unmapped", 8'h00, r);
        // Firmware keeps the reserved bits at zero on every write.
        wr_reg(EPS, 8'ha0);
        rd_reg(EPS, r);
        check("usb mode", 8'ha0, r);
        rd_reg(IST, r);
        // Engine drive reaches the pads one cycle late in USB mode.
        repeat (4) begin
            v = 8'($urandom % 8);
            host_u.engine(v[2:0]);
            @(posedge clk);
            #1 check("engine", {4'h0, v[2], v[0], v[1], v[0]},
                {4'h0, dminus_out, dminus_oe, dplus_out, dplus_oe});
        end
        host_u.engine(3'h0);
        // Bus reset sets the sticky flag and one interrupt pulse.
        n = pulses;
        host_u.pulse(4'h1);
        repeat (2) @(posedge clk);
        rd_reg(BSC, r);
        check("bus reset", bsc(0, 1, 0), r);
        check("irq pulse", 8'(n + 1), 8'(pulses));
        check("irq level", 8'h01, {7'h0, irq});
        // A masked status bit must not reach the level interrupt.
        wr_reg(IMK, 8'h1d);
        @(posedge clk);
        #1 check("irq masked", 8'h00, {7'h0, irq});
        wr_reg(IMK, 8'h1f);
        rd_reg(IST, r);
        check("status", 8'h02, r);
        repeat (3) @(posedge clk);
        check("irq clear", 8'h00, {7'h0, irq});
        wr_reg(BSC, 8'hc0);
        rd_reg(BSC, r);
        check("flag clear", bsc(0, 0, 0), r);
        // Endpoint flags: set, repeat dropped, cleared, stack full blocks interrupt.
        for (int i = 0; i < 2; i++) begin
            host_u.pulse(4'(4 << i));
            repeat (2) @(posedge clk);
            rd_reg(EPS, r);
            check("ep flag", 8'ha0 | 8'(1 << i), r);
            rd_reg(IST, r);
            check("ep status", 8'(8 << i), r);
            host_u.pulse(4'(4 << i));
            repeat (2) @(posedge clk);
            rd_reg(IST, r);
            check("ep dropped", 8'h00, r);
            wr_reg(EPS, 8'ha0);
            rd_reg(EPS, r);
            check("ep cleared", 8'ha0, r);
            stack_full <= 1'b1;
            n = pulses;
            host_u.pulse(4'(4 << i));
            repeat (2) @(posedge clk);
            check("stack full", 8'(n), 8'(pulses));
            rd_reg(EPS, r);
            check("ep again", 8'ha0 | 8'(1 << i), r);
            stack_full <= 1'b0;
            wr_reg(EPS, 8'ha0);
            rd_reg(IST, r);
        end
        // A disabled interrupt still flags the endpoint but raises no request.
        usb_int_enable <= 1'b0;
        n = pulses;
        host_u.pulse(4'h4);
        repeat (2) @(posedge clk);
        check("irq disabled", 8'(n), 8'(pulses));
        usb_int_enable <= 1'b1;
        wr_reg(EPS, 8'ha0);
        rd_reg(IST, r);
        check("ep disabled", 8'h08, r);
        // Suspend only after the full idle count, then resume and exit.
        n = pulses;
        host_u.busy(1'b0);
        repeat (8) @(posedge clk);
        rd_reg(BSC, r);
        check("not idle yet", bsc(0, 0, 0), r);
        repeat (IDLE) @(posedge clk);
        rd_reg(BSC, r);
        check("suspend", bsc(1, 0, 0), r);
        check("suspend irq", 8'(n + 1), 8'(pulses));
        host_u.pulse(4'h2);
        repeat (2) @(posedge clk);
        rd_reg(BSC, r);
        check("resume", bsc(1, 0, 1), r);
        host_u.busy(1'b1);
        repeat (3) @(posedge clk);
        rd_reg(BSC, r);
        check("awake", bsc(0, 0, 0), r);
        // PS/2 mode: random drive bits and host pulls on the two lines.
        wr_reg(EPS, 8'h10);
        repeat (8) begin
            v = 8'($urandom);
            wr_reg(BSC, {v[1:0], 6'h00});
            host_u.set_pull(v[3:2]);
            repeat (5) @(posedge clk);
            rd_reg(BSC, r);
            check("lines", {2'h0, line(v[1], v[3]), line(v[0], v[2]), 4'h0}, r);
            check("open drain", {6'h0, ~v[0], ~v[1]}, {6'h0, dminus_oe, dplus_oe});
        end
        finish_test();
    end
endmodule : test_usb_ps2_status_control_regs
